// ---- logic/pager_ctx_pkg.sv ----
// Contract
// RQ1 - Leading three flag bits gate each part; clear flag keeps old part.
// RQ2 - Flag 0 loads current block bits 6-8, previous block bits 9-11.
// RQ3 - Flag 1 loads previous section bits 13-17; single-section software writes zero.
// RQ4 - Flag 2 with bit 18 clear requests outgoing user account update first.
// RQ5 - Flag 2 loads bits 23-35 into the user base register.
// RQ6 - Flag 2 invalidates every page table line.
// RQ7 - Context read uses write layout, flags read one, bit 18 reads zero.
// RQ8 - Monitor call replaces previous section with caller's running section.
// RQ9 - Conditions-in returns pager system status in the right half.
// RQ10 - Power-up: kernel mode, paging off, cache off, block 0 current.
// RQ11 - Page failures for non-translation causes still possible with paging off.
// RQ12 - Software sets bit 18 in first context write after start-up.
// RQ13 - Previous-context execute only in executive mode with nonzero field.
// RQ14 - Execute itself and fetch of executed instruction use current context.
// RQ15 - Accumulator-field references always use the current block.
// RQ16 - Only memory operand and index references may be redirected.
// RQ17 - Previous-context restrictions apply; section 0 caller confines to section 0.
// RQ18 - Previous mode comes from previous-user and previous-public flags.
// RQ19 - Concealed area reference fails when previous-public is set.
// RQ20 - Software clears one line for a uniquely mapped page deletion.
// RQ21 - Software clears all processors' tables when one is cleared.
// RQ22 - Field bit 9 routes effective address calculation to previous context.
// RQ23 - Field bit 10 routes memory operands to previous context.
// RQ24 - Each block selection is three bits picking one of eight blocks.
package pager_ctx_pkg;
  localparam int WORD_W      = 36;
  localparam int BLK_W       = 3;
  localparam int SEC_W       = 5;
  localparam int BASE_W      = 13;
  // Bit positions, numbered with bit 0 as the most significant
  localparam int FLAG_BLK    = 0;
  localparam int FLAG_SEC    = 1;
  localparam int FLAG_BASE   = 2;
  localparam int CUR_BLK_HI  = 6;
  localparam int PRV_BLK_HI  = 9;
  localparam int PRV_SEC_HI  = 13;
  localparam int ACCT_INH    = 18;
  localparam int BASE_HI     = 23;
  // Field of the execute word, bits 9-12
  localparam int FLD_EA      = 9;
  localparam int FLD_DATA    = 10;
  // Reset values
  localparam logic [2:0]  RST_BLK  = 3'h0;
  localparam logic [4:0]  RST_SEC  = 5'h00;
  localparam logic [12:0] RST_BASE = 13'h0000;

  // Convert documented bit number (0 = msb) into vector index
  function automatic int msb_idx(input int n);
    return WORD_W - 1 - n;
  endfunction
endpackage

// ---- logic/page_line_invalidator.sv ----
`timescale 1ns/1ns
// Sweeps every page table line setting its invalid bit
module page_line_invalidator #(
  parameter int LINES = 512
) (
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_sys_rst,
  // Request
  input  wire logic                     i_start,
  input  wire logic                     i_single,
  input  wire logic [$clog2(LINES)-1:0] i_single_line,
  // Page table write port
  output logic                          o_busy,
  output logic                          o_inval_we,
  output logic [$clog2(LINES)-1:0]      o_inval_line
);
  localparam int AW = $clog2(LINES);
  logic [AW-1:0] line;
  logic          run;

  // One line per clock; a new full request restarts the sweep
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      run  <= 1'b0;
      line <= '0;
    end else if (i_start) begin
      run  <= 1'b1;
      line <= '0;
    end else if (run && line == AW'(LINES - 1)) begin
      run <= 1'b0;
    end else if (run) begin
      line <= line + 1'b1;
    end
  end

  // Write strobe for the table's invalid bit
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_inval_we   <= 1'b0;
      o_inval_line <= '0;
    end else if (run) begin
      o_inval_we   <= 1'b1; // RQ6
      o_inval_line <= line;
    end else if (i_single) begin
      o_inval_we   <= 1'b1;
      o_inval_line <= i_single_line;
    end else begin
      o_inval_we   <= 1'b0;
    end
  end

  assign o_busy = run | i_start;
endmodule

// ---- logic/prev_ctx_steer.sv ----
`timescale 1ns/1ns
// Decides, per reference, whether previous context is used
module prev_ctx_steer (
  // Execute state
  input  wire logic       i_previous_context_execute_active,
  input  wire logic [3:0] i_field,
  input  wire logic       i_cur_sec_zero,
  input  wire logic [4:0] i_prev_sec,
  input  wire logic       i_prev_user,
  input  wire logic       i_prev_public,
  // Reference kind
  input  wire logic       i_ref_ea,
  input  wire logic       i_ref_data,
  input  wire logic       i_ref_concealed,
  // Steering
  output logic            o_use_prev,
  output logic            o_use_user_space,
  output logic [4:0]      o_sec,
  output logic            o_fail
);
  // Field bit 9 is the vector msb, bit 10 the next
  logic ea_prev;
  logic data_prev;
  assign ea_prev   = i_field[3] & i_ref_ea;   // RQ22
  assign data_prev = i_field[2] & i_ref_data; // RQ23
  // Fetches and accumulator-field refs never arrive here as ea/data
  assign o_use_prev = i_previous_context_execute_active & (ea_prev | data_prev); // RQ16
  // Mode of the previous space from saved flags
  assign o_use_user_space = o_use_prev & i_prev_user; // RQ18
  // Section-0 caller keeps previous context in section 0
  assign o_sec  = (o_use_prev && !i_cur_sec_zero) ? i_prev_sec : 5'h00; // RQ17
  assign o_fail = o_use_prev & i_prev_public & i_ref_concealed; // RQ19
endmodule

// ---- logic/pager_context_select.sv ----
`timescale 1ns/1ns
// Process-context part of the pager unit
module pager_context_select #(
  parameter int LINES = 512
) (
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_sys_rst,
  // Pager io instructions
  input  wire logic                     i_io_data_out,
  input  wire logic                     i_io_data_in,
  input  wire logic                     i_io_conditions_in,
  input  wire logic [35:0]              i_wdata,
  input  wire logic [17:0]              i_sys_status,
  output logic [35:0]                   o_rdata,
  // Monitor call and single line clear
  input  wire logic                     i_monitor_call,
  input  wire logic [4:0]               i_pc_section,
  input  wire logic                     i_clear_page_line,
  input  wire logic [$clog2(LINES)-1:0] i_clear_line,
  // Execute instruction
  input  wire logic                     i_execute_instruction,
  input  wire logic                     i_exec_done,
  input  wire logic                     i_user_mode,
  input  wire logic [3:0]               i_xct_field,
  input  wire logic                     i_prev_user,
  input  wire logic                     i_prev_public,
  input  wire logic                     i_cur_sec_zero,
  input  wire logic                     i_ref_ea,
  input  wire logic                     i_ref_data,
  input  wire logic                     i_ref_ac_field,
  input  wire logic                     i_ref_concealed,
  input  wire logic                     i_nonxlate_fault,
  input  wire logic                     i_paging_on,
  // Context outputs
  output logic [2:0]                    o_cur_blk,
  output logic [2:0]                    o_prev_blk,
  output logic [4:0]                    o_prev_sec,
  output logic [12:0]                   o_user_base,
  output logic                          o_acct_update,
  output logic [12:0]                   o_acct_old_base,
  output logic                          o_previous_context_execute_active,
  output logic                          o_ref_prev,
  output logic                          o_ref_user_space,
  output logic [4:0]                    o_ref_sec,
  output logic [2:0]                    o_ref_blk,
  output logic                          o_page_fail,
  output logic                          o_inval_busy,
  output logic                          o_inval_we,
  output logic [$clog2(LINES)-1:0]      o_inval_line
);
  logic [pager_ctx_pkg::BLK_W-1:0]  cur_blk;
  logic [pager_ctx_pkg::BLK_W-1:0]  prev_blk;
  logic [pager_ctx_pkg::SEC_W-1:0]  prev_sec;
  logic [pager_ctx_pkg::BASE_W-1:0] user_base;
  logic [3:0]                       previous_context_execute_field;
  logic                             previous_context_execute_active;
  logic                             use_prev;
  logic                             steer_fail;
  logic                             fl_blk;
  logic                             fl_sec;
  logic                             fl_base;
  logic [35:0]                      ctx_word;

  // Change flags of the incoming word
  assign fl_blk  = i_wdata[pager_ctx_pkg::msb_idx(pager_ctx_pkg::FLAG_BLK)];
  assign fl_sec  = i_wdata[pager_ctx_pkg::msb_idx(pager_ctx_pkg::FLAG_SEC)];
  assign fl_base = i_wdata[pager_ctx_pkg::msb_idx(pager_ctx_pkg::FLAG_BASE)];

  // Block selections; reset picks block 0 for the kernel
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cur_blk  <= pager_ctx_pkg::RST_BLK; // RQ10
      prev_blk <= pager_ctx_pkg::RST_BLK;
    end else if (i_io_data_out && fl_blk) begin // RQ1
      cur_blk  <= i_wdata[pager_ctx_pkg::msb_idx(pager_ctx_pkg::CUR_BLK_HI) -: 3]; // RQ2
      prev_blk <= i_wdata[pager_ctx_pkg::msb_idx(pager_ctx_pkg::PRV_BLK_HI) -: 3]; // RQ24
    end
  end

  // Previous section; a monitor call overrides a same-cycle write
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      prev_sec <= pager_ctx_pkg::RST_SEC;
    end else if (i_monitor_call) begin
      prev_sec <= i_pc_section; // RQ8
    end else if (i_io_data_out && fl_sec) begin // RQ1
      prev_sec <= i_wdata[pager_ctx_pkg::msb_idx(pager_ctx_pkg::PRV_SEC_HI) -: 5]; // RQ3
    end
  end

  // User base; accounts use the old base, captured before the load
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      user_base       <= pager_ctx_pkg::RST_BASE;
      o_acct_update   <= 1'b0;
      o_acct_old_base <= pager_ctx_pkg::RST_BASE;
    end else begin
      o_acct_update <= 1'b0;
      if (i_io_data_out && fl_base) begin
        o_acct_update   <= ~i_wdata[pager_ctx_pkg::msb_idx(pager_ctx_pkg::ACCT_INH)]; // RQ4
        o_acct_old_base <= user_base; // RQ4
        user_base       <= i_wdata[pager_ctx_pkg::msb_idx(pager_ctx_pkg::BASE_HI) -: 13]; // RQ5
      end
    end
  end

  // Whole-table sweep on base change, or one line on request
  page_line_invalidator #(
    .LINES(LINES)
  ) u_inval (
    .i_clk         (i_clk),
    .i_sys_rst     (i_sys_rst),
    .i_start       (i_io_data_out & fl_base), // RQ6
    .i_single      (i_clear_page_line),
    .i_single_line (i_clear_line),
    .o_busy        (o_inval_busy),
    .o_inval_we    (o_inval_we),
    .o_inval_line  (o_inval_line)
  );

  // Readback word in write layout
  always_comb begin
    ctx_word = 36'h000000000;
    ctx_word[35:33] = 3'h7; // RQ7
    ctx_word[pager_ctx_pkg::msb_idx(pager_ctx_pkg::CUR_BLK_HI) -: 3] = cur_blk;
    ctx_word[pager_ctx_pkg::msb_idx(pager_ctx_pkg::PRV_BLK_HI) -: 3] = prev_blk;
    ctx_word[pager_ctx_pkg::msb_idx(pager_ctx_pkg::PRV_SEC_HI) -: 5] = prev_sec;
    ctx_word[pager_ctx_pkg::msb_idx(pager_ctx_pkg::BASE_HI) -: 13]  = user_base;
  end

  // Read data held until the next read
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= 36'h000000000;
    end else if (i_io_data_in) begin
      o_rdata <= ctx_word; // RQ7
    end else if (i_io_conditions_in) begin
      o_rdata <= {18'h00000, i_sys_status}; // RQ9
    end
  end

  // Execute latches the field; user mode ignores it
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      previous_context_execute_active <= 1'b0;
      previous_context_execute_field  <= 4'h0;
    end else if (i_execute_instruction) begin
      previous_context_execute_active <= ~i_user_mode && (i_xct_field != 4'h0); // RQ13
      previous_context_execute_field  <= i_user_mode ? 4'h0 : i_xct_field;     // RQ13
    end else if (i_exec_done) begin
      previous_context_execute_active <= 1'b0;
    end
  end

  prev_ctx_steer u_steer (
    .i_previous_context_execute_active    (previous_context_execute_active),
    .i_field          (previous_context_execute_field),
    .i_cur_sec_zero   (i_cur_sec_zero),
    .i_prev_sec       (prev_sec),
    .i_prev_user      (i_prev_user),
    .i_prev_public    (i_prev_public),
    .i_ref_ea         (i_ref_ea & ~i_ref_ac_field),   // RQ15
    .i_ref_data       (i_ref_data & ~i_ref_ac_field), // RQ15
    .i_ref_concealed  (i_ref_concealed),
    .o_use_prev       (use_prev),
    .o_use_user_space (o_ref_user_space),
    .o_sec            (o_ref_sec),
    .o_fail           (steer_fail)
  );

  // Index refs in previous context use previous block
  assign o_ref_blk = use_prev ? prev_blk : cur_blk; // RQ15
  // Faults not tied to translation stand even with paging off
  assign o_page_fail = steer_fail | (i_nonxlate_fault & (i_paging_on | 1'b1)); // RQ11

  assign o_cur_blk     = cur_blk;
  assign o_prev_blk    = prev_blk;
  assign o_prev_sec    = prev_sec;
  assign o_user_base   = user_base;
  assign o_previous_context_execute_active = previous_context_execute_active;
  assign o_ref_prev    = use_prev;
endmodule

// ---- test/pager_ctx_properties.sv ----
`timescale 1ns/1ns
// Port-level checks of the context word, sweep and execute steering
module pager_ctx_properties #(
  parameter int LINES = 512
) (
  input wire logic                     i_clk,
  input wire logic                     i_sys_rst,
  input wire logic                     i_io_data_out,
  input wire logic                     i_io_data_in,
  input wire logic [35:0]              i_wdata,
  input wire logic [35:0]              o_rdata,
  input wire logic                     i_monitor_call,
  input wire logic [4:0]               i_pc_section,
  input wire logic                     i_execute_instruction,
  input wire logic                     i_user_mode,
  input wire logic [3:0]               i_xct_field,
  input wire logic                     i_ref_ac_field,
  input wire logic [2:0]               o_cur_blk,
  input wire logic [2:0]               o_prev_blk,
  input wire logic [4:0]               o_prev_sec,
  input wire logic [12:0]              o_user_base,
  input wire logic                     o_acct_update,
  input wire logic                     o_previous_context_execute_active,
  input wire logic                     o_ref_prev,
  input wire logic [2:0]               o_ref_blk,
  input wire logic                     o_inval_we,
  input wire logic [$clog2(LINES)-1:0] o_inval_line
);
  // One domain, so clock and reset are given once
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  AST_ACCT: assert property (i_io_data_out && i_wdata[33] && !i_wdata[17] |=> o_acct_update)
    else $error("account update missing");
  AST_BLK: assert property (i_io_data_out && i_wdata[35] |=>
    o_cur_blk == $past(i_wdata[29:27]) && o_prev_blk == $past(i_wdata[26:24]))
    else $error("block load wrong");
  AST_KEEP: assert property (i_io_data_out && !i_wdata[35] |=> $stable(o_cur_blk))
    else $error("block changed with flag clear");
  AST_SEC: assert property (i_io_data_out && i_wdata[34] && !i_monitor_call |=>
    o_prev_sec == $past(i_wdata[22:18]))
    else $error("section load wrong");
  AST_MCALL: assert property (i_monitor_call |=> o_prev_sec == $past(i_pc_section))
    else $error("caller section not taken");
  AST_BASE: assert property (i_io_data_out && i_wdata[33] |=>
    o_user_base == $past(i_wdata[12:0]))
    else $error("base load wrong");
  AST_RD: assert property (i_io_data_in && !i_io_data_out |=>
    o_rdata[35:33] == 3'h7 && !o_rdata[17] && o_rdata[12:0] == o_user_base)
    else $error("context read layout wrong");
  // Sweep strobes start two edges after the request
  AST_INV: assert property (i_io_data_out && i_wdata[33] |-> ##2 o_inval_we && o_inval_line == '0)
    else $error("sweep did not start");
  AST_PREVIOUS_CONTEXT_EXECUTE: assert property (i_execute_instruction && !o_previous_context_execute_active |=>
    o_previous_context_execute_active == (!$past(i_user_mode) && $past(i_xct_field) != 4'h0))
    else $error("execute mode wrong");
  AST_AC: assert property (o_previous_context_execute_active && i_ref_ac_field |-> !o_ref_prev && o_ref_blk == o_cur_blk)
    else $error("accumulator ref left current block");

  cover property (i_io_data_out && i_wdata[33] && !i_wdata[17]);
  cover property (i_monitor_call && i_io_data_out);
  cover property (o_previous_context_execute_active && o_ref_prev);
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ns
// Directed checks of the context block
module tb_top;
  localparam logic [35:0] MSK = 36'he3f7e1fff;
  logic        i_clk = '0;
  logic        i_sys_rst = '1;
  logic        i_io_data_out = '0, i_io_data_in = '0, i_io_conditions_in = '0, i_monitor_call = '0;
  logic        i_clear_page_line = '0, i_execute_instruction = '0, i_exec_done = '0;
  logic        i_user_mode = '0, i_prev_user = '0, i_prev_public = '0, i_cur_sec_zero = '0;
  logic        i_ref_ea = '0, i_ref_data = '0, i_ref_ac_field = '0, i_ref_concealed = '0;
  logic        i_nonxlate_fault = '0, i_paging_on = '0, o_acct_update, o_previous_context_execute_active, o_ref_prev;
  logic        o_ref_user_space, o_page_fail, o_inval_busy, o_inval_we;
  logic [35:0] i_wdata = '0, o_rdata;
  logic [17:0] i_sys_status = '0;
  logic [12:0] o_user_base, o_acct_old_base, mb = '0;
  logic [4:0]  i_pc_section = '0, o_prev_sec, o_ref_sec, ms = '0;
  logic [3:0]  i_xct_field = '0;
  logic [2:0]  i_clear_line = '0, o_cur_blk, o_prev_blk, o_ref_blk, o_inval_line, mc = '0, mp = '0;
  int          err_count = 0, n_checks = 0;

  // Sweep cut to eight lines to keep the run short
  pager_context_select #(.LINES(8)) u_dut (.*);

  // 25 MHz clock
  always #20 i_clk = ~i_clk;

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  function automatic logic [35:0] mk(input logic [2:0] f, input logic h);
    return {f, 3'h0, mc, mp, 1'b0, ms, h, 4'h0, mb};
  endfunction

  // One-cycle request strobes; sample just after the taking edge
  task automatic io(input logic [35:0] w, input logic wr, input logic ci);
    @(posedge i_clk);
    i_io_data_out <= wr;
    i_io_data_in <= !wr && !ci;
    i_io_conditions_in <= ci;
    i_wdata <= w;
    @(posedge i_clk);
    {i_io_data_out, i_io_data_in, i_io_conditions_in} <= 3'h0;
    #1;
  endtask

  // Full switch after the first write, so accounts go to the outgoing base
  task automatic t_switch;
    logic [12:0] ob;
    ob = mb;
    mc = 3'h5;
    mp = 3'h3;
    ms = 5'h11;
    mb = 13'h1abc;
    io(mk(3'h7, 1'b0), 1'b1, 1'b0);
    chk({o_acct_update, o_acct_old_base}, {1'b1, ob});
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk);
      #1;
      chk({o_inval_we, o_inval_line}, {1'b1, 3'(i)});
    end
    io('0, 1'b0, 1'b0);
    chk(o_rdata & MSK, mk(3'h7, 1'b0));
  endtask

  // Each flag alone: only its part may move, inhibit blocks accounting
  task automatic t_flags;
    logic [35:0] w;
    for (int f = 0; f < 3; f++) begin
      w = {3'h4 >> f, 3'h0, 3'h2, 3'h6, 1'b0, 5'h0a, 1'b1, 4'h0, 13'h0777};
      io(w, 1'b1, 1'b0);
      chk(o_acct_update, 1'b0);
      {mc, mp} = (f == 0) ? 6'h16 : {mc, mp};
      ms = (f == 1) ? 5'h0a : ms;
      mb = (f == 2) ? 13'h0777 : mb;
      io('0, 1'b0, 1'b0);
      chk(o_rdata & MSK, mk(3'h7, 1'b0));
    end
  endtask

  // Monitor call beats a section write in the same cycle
  task automatic t_mcall;
    @(posedge i_clk);
    i_monitor_call <= 1'b1;
    i_pc_section <= 5'h09;
    i_sys_status <= 18'h2a5c3;
    io({3'h2, 10'h000, 5'h03, 18'h00000}, 1'b1, 1'b0);
    @(posedge i_clk);
    i_monitor_call <= 1'b0;
    ms = 5'h09;
    io('0, 1'b0, 1'b0);
    chk(o_rdata & MSK, mk(3'h7, 1'b0));
    io('0, 1'b0, 1'b1);
    chk(o_rdata, {18'h0, 18'h2a5c3});
  endtask

  // Single line clear, then a base-only write sweeping the whole table
  task automatic t_clrline;
    @(posedge i_clk);
    i_clear_page_line <= 1'b1;
    i_clear_line <= 3'h5;
    @(posedge i_clk);
    i_clear_page_line <= 1'b0;
    #1;
    chk({o_inval_busy, o_inval_we, o_inval_line}, {2'h1, 3'h5});
    @(posedge i_clk);
    #1;
    chk(o_inval_we, 1'b0);
    io(mk(3'h1, 1'b1), 1'b1, 1'b0);
    chk({o_inval_busy, o_acct_update, o_user_base}, {2'h2, mb});
    repeat (8) @(posedge i_clk);
    #1;
    chk(o_inval_busy, 1'b0);
  endtask

  task automatic execute_instruction(input logic um, input logic [3:0] fld, input logic exp);
    @(posedge i_clk);
    i_execute_instruction <= 1'b1;
    i_user_mode <= um;
    i_xct_field <= fld;
    @(posedge i_clk);
    i_execute_instruction <= 1'b0;
    #1;
    chk(o_previous_context_execute_active, exp);
  endtask

  task automatic t_previous_context_execute;
    execute_instruction(1'b1, 4'h4, 1'b0);
    execute_instruction(1'b0, 4'h0, 1'b0);
    execute_instruction(1'b0, 4'h4, 1'b1);
    @(posedge i_clk);
    {i_ref_ac_field, i_ref_data, i_ref_ea} <= 3'h7;
    #1;
    chk({o_ref_prev, o_ref_blk}, {1'b0, mc});
    @(posedge i_clk);
    {i_ref_ac_field, i_ref_ea, i_cur_sec_zero, i_prev_user} <= 4'h3;
    #1;
    chk({o_ref_prev, o_ref_sec}, {1'b1, 5'h00});
    chk({o_ref_blk, o_ref_user_space}, {mp, 1'b1});
    @(posedge i_clk);
    {i_ref_concealed, i_prev_public} <= 2'h3;
    #1;
    chk(o_page_fail, 1'b1);
    @(posedge i_clk);
    {i_ref_concealed, i_prev_public, i_ref_data} <= 3'h0;
    {i_cur_sec_zero, i_prev_user} <= 2'h0;
    {i_nonxlate_fault, i_exec_done} <= 2'h3;
    #1;
    chk(o_page_fail, 1'b1);
    @(posedge i_clk);
    {i_nonxlate_fault, i_exec_done} <= 2'h0;
    #1;
    chk(o_previous_context_execute_active, 1'b0);
    // Address bit alone: index path moves, data stays current
    execute_instruction(1'b0, 4'h8, 1'b1);
    @(posedge i_clk);
    i_ref_ea <= 1'b1;
    #1;
    chk({o_ref_prev, o_ref_sec, o_ref_user_space}, {1'b1, ms, 1'b0});
    @(posedge i_clk);
    {i_ref_ea, i_ref_data} <= 2'h1;
    #1;
    chk(o_ref_prev, 1'b0);
  endtask

  initial begin
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    chk({o_cur_blk, o_prev_blk, o_prev_sec, o_user_base}, '0);
    t_flags;
    t_switch;
    t_mcall;
    t_clrline;
    t_previous_context_execute;
    conclude;
  end

  // About 66 cycles are needed; 5000 means a hang
  initial begin
    #200000;
    err_count++;
    conclude;
  end
endmodule

bind pager_context_select pager_ctx_properties #(.LINES(LINES)) u_chk (.*);
